// File: src/hti_dev.sv
`timescale 1ns/1ps
module hti_dev #(
    parameter int STABLE_CYCLES = hti_pkg::STABLE_CYC,
    parameter int MEAS_CYCLES = hti_pkg::MEAS_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    hti_if.dev bus,
    input wire logic [19:0] hum_sample,
    input wire logic [19:0] temp_sample,
    output logic ready,
    output logic bus_busy,
    output logic [7:0] status_byte,
    output logic [19:0] hum_result,
    output logic [19:0] temp_result
);
    typedef enum logic [2:0] {
        HTI_IDLE = 3'b000,
        HTI_ADDR = 3'b001,
        HTI_WRX = 3'b010,
        HTI_RTX = 3'b011,
        HTI_RACK = 3'b100,
        HTI_IGN = 3'b101
    } hti_dev_e;

    // ======================================================
    // pin sync and edges
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic scl_d;
    logic sda_d;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            scl_s <= 2'h3;
            sda_s <= 2'h3;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_s <= {scl_s[0], bus.scl};
            sda_s <= {sda_s[0], bus.sda};
            scl_d <= scl_s[1];
            sda_d <= sda_s[1];
        end
    end
    wire logic scl_rise = scl_s[1] && !scl_d;
    wire logic scl_fall = !scl_s[1] && scl_d;
    wire logic start_ev = scl_s[1] && scl_d && sda_d && !sda_s[1];
    wire logic stop_ev = scl_s[1] && scl_d && !sda_d && sda_s[1];

    // ======================================================
    // power-on stabilisation
    logic [31:0] stab_cnt;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            stab_cnt <= 32'h0;
            ready <= 1'b0;
        end else if (!ready) begin
            stab_cnt <= stab_cnt + 32'h1;
            ready <= (stab_cnt >= 32'(STABLE_CYCLES - 1));
        end
    end

    // ======================================================
    // byte engine
    hti_dev_e state;
    logic [7:0] shreg;
    logic [3:0] bitn;
    logic ack_phase;
    logic [2:0] wr_idx;
    logic [7:0] cmd0;
    logic [7:0] cmd1;
    logic [2:0] rd_idx;
    logic [7:0] crc;
    logic sda_oe;
    logic calibrated;
    logic busy;
    logic [31:0] meas_cnt;
    logic init_pulse;
    logic trig_pulse;

    function automatic logic [7:0] rd_byte(input logic [2:0] i, input logic [7:0] st,
                                           input logic [19:0] h, input logic [19:0] t,
                                           input logic [7:0] c);
        case (i)
            3'h0: rd_byte = st;
            3'h1: rd_byte = h[19:12];
            3'h2: rd_byte = h[11:4];
            3'h3: rd_byte = {h[3:0], t[19:16]};
            3'h4: rd_byte = t[15:8];
            3'h5: rd_byte = t[7:0];
            default: rd_byte = c;
        endcase
    endfunction

    always_comb begin
        status_byte = hti_pkg::STAT_RESET;
        status_byte[hti_pkg::STAT_BUSY_BIT] = busy;
        status_byte[hti_pkg::STAT_CAL_BIT] = calibrated;
    end

    wire logic [7:0] cur_rd = rd_byte(rd_idx, status_byte, hum_result, temp_result, crc);
    wire logic [7:0] rx_byte = {shreg[6:0], sda_s[1]};

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state <= HTI_IDLE;
            bus_busy <= 1'b0;
            shreg <= 8'h00;
            bitn <= 4'h0;
            ack_phase <= 1'b0;
            wr_idx <= 3'h0;
            cmd0 <= 8'h00;
            cmd1 <= 8'h00;
            rd_idx <= 3'h0;
            crc <= hti_pkg::CRC_INIT;
            sda_oe <= 1'b0;
            init_pulse <= 1'b0;
            trig_pulse <= 1'b0;
        end else begin
            init_pulse <= 1'b0;
            trig_pulse <= 1'b0;
            if (stop_ev) begin
                state <= HTI_IDLE;
                bus_busy <= 1'b0;
                sda_oe <= 1'b0;
            end else if (start_ev) begin
                bus_busy <= 1'b1;
                state <= ready ? HTI_ADDR : HTI_IGN;
                bitn <= 4'h0;
                ack_phase <= 1'b0;
                sda_oe <= 1'b0;
            end else begin
                case (state)
                    HTI_ADDR, HTI_WRX: begin
                        if (scl_rise && !ack_phase) begin
                            shreg <= rx_byte;
                            bitn <= bitn + 4'h1;
                        end else if (scl_fall && !ack_phase && bitn == 4'h8) begin
                            bitn <= 4'h0;
                            if (state == HTI_ADDR) begin
                                if (shreg[7:1] == hti_pkg::TARGET_ADDR) begin
                                    ack_phase <= 1'b1;
                                    sda_oe <= 1'b1;
                                    wr_idx <= 3'h0;
                                    rd_idx <= 3'h0;
                                    crc <= hti_pkg::CRC_INIT;
                                end else begin
                                    state <= HTI_IGN;
                                end
                            end else begin
                                ack_phase <= 1'b1;
                                sda_oe <= 1'b1;
                                if (wr_idx == 3'h0) begin
                                    cmd0 <= shreg;
                                end else if (wr_idx == 3'h1) begin
                                    cmd1 <= shreg;
                                end else if (wr_idx == 3'h2) begin
                                    if (cmd0 == hti_pkg::CMD_INIT && cmd1 == hti_pkg::INIT_P0
                                        && shreg == hti_pkg::INIT_P1) begin
                                        init_pulse <= 1'b1;
                                    end
                                    if (cmd0 == hti_pkg::CMD_TRIG && cmd1 == hti_pkg::TRIG_P0
                                        && shreg == hti_pkg::TRIG_P1) begin
                                        trig_pulse <= 1'b1;
                                    end
                                end
                                if (wr_idx != 3'h7) begin
                                    wr_idx <= wr_idx + 3'h1;
                                end
                            end
                        end else if (scl_fall && ack_phase) begin
                            ack_phase <= 1'b0;
                            if (state == HTI_ADDR && shreg[0]) begin
                                // first data bit goes out right after this fall
                                state <= HTI_RTX;
                                sda_oe <= !cur_rd[7];
                                shreg <= {cur_rd[6:0], 1'b0};
                                crc <= hti_pkg::crc_step(crc, cur_rd);
                                bitn <= 4'h1;
                            end else begin
                                state <= HTI_WRX;
                                sda_oe <= 1'b0;
                            end
                        end
                    end
                    HTI_RTX: begin
                        if (scl_fall) begin
                            if (bitn == 4'h8) begin
                                sda_oe <= 1'b0;
                                state <= HTI_RACK;
                            end else begin
                                sda_oe <= !shreg[7];
                                shreg <= {shreg[6:0], 1'b0};
                                bitn <= bitn + 4'h1;
                            end
                        end
                    end
                    HTI_RACK: begin
                        if (scl_rise) begin
                            if (sda_s[1]) begin
                                state <= HTI_IGN;
                            end else if (rd_idx != 3'h6) begin
                                rd_idx <= rd_idx + 3'h1;
                            end
                        end else if (scl_fall) begin
                            state <= HTI_RTX;
                            sda_oe <= !cur_rd[7];
                            shreg <= {cur_rd[6:0], 1'b0};
                            crc <= hti_pkg::crc_step(crc, cur_rd);
                            bitn <= 4'h1;
                        end
                    end
                    default: begin
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ======================================================
    // calibration and measurement
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            calibrated <= 1'b0;
            busy <= 1'b0;
            meas_cnt <= 32'h0;
            hum_result <= 20'h0;
            temp_result <= 20'h0;
        end else begin
            if (init_pulse) begin
                calibrated <= 1'b1;
            end
            if (trig_pulse && !busy) begin
                busy <= 1'b1;
                meas_cnt <= 32'h0;
            end else if (busy) begin
                if (meas_cnt >= 32'(MEAS_CYCLES - 1)) begin
                    hum_result <= hum_sample;
                    temp_result <= temp_sample;
                    busy <= 1'b0;
                end else begin
                    meas_cnt <= meas_cnt + 32'h1;
                end
            end
        end
    end

    assign bus.sda_dev_o = 1'b0;
    assign bus.sda_dev_oe = sda_oe;
endmodule

// File: src/hti_pkg.sv
package hti_pkg;
    // ======================================================
    // bus addressing and commands
    localparam logic [6:0] TARGET_ADDR = 7'h38;
    localparam logic [7:0] CMD_STATUS = 8'h71;
    localparam logic [7:0] CMD_INIT = 8'hbe;
    localparam logic [7:0] INIT_P0 = 8'h08;
    localparam logic [7:0] INIT_P1 = 8'h00;
    localparam logic [7:0] CMD_TRIG = 8'hac;
    localparam logic [7:0] TRIG_P0 = 8'h33;
    localparam logic [7:0] TRIG_P1 = 8'h00;
    // ======================================================
    // status byte layout
    localparam int STAT_BUSY_BIT = 7;
    localparam int STAT_CAL_BIT = 3;
    localparam logic [7:0] STAT_RESET = 8'h00;
    localparam int RESULT_BYTES = 6;
    localparam int RES_W = 20;
    // ======================================================
    // timing, clock 20 MHz
    localparam int CLK_HZ = 20000000;
    localparam int STABLE_MS = 100;
    localparam int HOST_WAIT_MS = 40;
    localparam int MEAS_MS = 75;
    localparam int STABLE_CYC = CLK_HZ / 1000 * STABLE_MS;
    localparam int MEAS_CYC = CLK_HZ / 1000 * MEAS_MS;
    localparam int SCL_KHZ = 100;
    // half period of host scl, rounded up so frequency stays under the limit
    localparam int SCL_HALF_CYC = (CLK_HZ / 1000 + 2 * SCL_KHZ - 1) / (2 * SCL_KHZ);
    // ======================================================
    // crc-8, poly x^8+x^5+x^4+1, init ff
    localparam logic [7:0] CRC_POLY = 8'h31;
    localparam logic [7:0] CRC_INIT = 8'hff;

    function automatic logic [7:0] crc_step(input logic [7:0] crc, input logic [7:0] d);
        logic [7:0] c;
        c = crc ^ d;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
        end
        return c;
    endfunction
endpackage

// File: src/hti_if.sv
`timescale 1ns/1ps
interface hti_if;
    logic scl_o;
    logic scl_oe;
    logic sda_dev_o;
    logic sda_dev_oe;
    logic sda_host_o;
    logic sda_host_oe;
    wire scl;
    wire sda;
    // open drain with pull-up: any enabled low driver pulls the line
    assign scl = !(scl_oe && !scl_o);
    assign sda = !((sda_dev_oe && !sda_dev_o) || (sda_host_oe && !sda_host_o));

    modport dev (
        input scl,
        input sda,
        output sda_dev_o,
        output sda_dev_oe
    );
    modport host (
        input scl,
        input sda,
        output scl_o,
        output scl_oe,
        output sda_host_o,
        output sda_host_oe
    );
endinterface

// File: src/hti_host.sv
`timescale 1ns/1ps
module hti_host #(
    parameter int WAIT_CYCLES = hti_pkg::STABLE_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    hti_if.host bus,
    input wire logic go,
    input wire logic rd,
    input wire logic [1:0] nbytes,
    input wire logic [7:0] wb0,
    input wire logic [7:0] wb1,
    input wire logic [7:0] wb2,
    input wire logic [2:0] rd_len,
    output logic ready,
    output logic busy,
    output logic done,
    output logic nacked,
    output logic [7:0] rd_data,
    output logic rd_valid
);
    typedef enum logic [2:0] {
        HTH_IDLE = 3'b000,
        HTH_START = 3'b001,
        HTH_BIT = 3'b010,
        HTH_STOP = 3'b011,
        HTH_END = 3'b100
    } hti_host_e;

    // ======================================================
    // sync sda, divider for scl phases
    logic [1:0] sda_s;
    logic [15:0] div;
    logic tick;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sda_s <= 2'h3;
            div <= 16'h0;
        end else begin
            sda_s <= {sda_s[0], bus.sda};
            div <= tick ? 16'h0 : div + 16'h1;
        end
    end
    assign tick = (div == 16'(hti_pkg::SCL_HALF_CYC - 1));

    // power-on wait, longer of both figures
    logic [31:0] wcnt;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wcnt <= 32'h0;
            ready <= 1'b0;
        end else if (!ready) begin
            wcnt <= wcnt + 32'h1;
            ready <= (wcnt >= 32'(WAIT_CYCLES - 1));
        end
    end

    hti_host_e state;
    logic scl_q;
    logic sda_q;
    logic ph;
    logic [3:0] bitn;
    logic [2:0] bidx;
    logic [7:0] sh;
    logic rdm;
    logic [2:0] len;
    logic [23:0] wbuf;
    logic [1:0] wn;

    // byte count excludes the address byte, which is bidx 0
    wire logic last = rdm ? (bidx == len) : (bidx == {1'b0, wn});

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state <= HTH_IDLE;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            ph <= 1'b0;
            bitn <= 4'h0;
            bidx <= 3'h0;
            sh <= 8'h00;
            rdm <= 1'b0;
            len <= 3'h0;
            wbuf <= 24'h0;
            wn <= 2'h0;
            done <= 1'b0;
            nacked <= 1'b0;
            rd_data <= 8'h00;
            rd_valid <= 1'b0;
        end else begin
            done <= 1'b0;
            rd_valid <= 1'b0;
            case (state)
                HTH_IDLE: begin
                    if (go && ready) begin
                        rdm <= rd;
                        len <= rd_len;
                        wn <= nbytes;
                        wbuf <= {wb0, wb1, wb2};
                        sh <= {hti_pkg::TARGET_ADDR, rd};
                        nacked <= 1'b0;
                        bidx <= 3'h0;
                        state <= HTH_START;
                    end
                end
                HTH_START: begin
                    if (tick) begin
                        sda_q <= 1'b0;
                        state <= HTH_BIT;
                        ph <= 1'b0;
                        bitn <= 4'h0;
                    end
                end
                HTH_BIT: begin
                    if (tick) begin
                        ph <= !ph;
                        if (!ph) begin
                            scl_q <= 1'b0;
                            if (bitn < 4'h8) begin
                                sda_q <= (rdm && bidx != 3'h0) ? 1'b1 : sh[7];
                            end else begin
                                // ack bit: ack reads except the last, which is nacked; release on writes
                                sda_q <= !(rdm && bidx != 3'h0) || last;
                            end
                        end else begin
                            scl_q <= 1'b1;
                            if (bitn < 4'h8) begin
                                sh <= {sh[6:0], sda_s[1]};
                                bitn <= bitn + 4'h1;
                            end else begin
                                if (rdm && bidx != 3'h0) begin
                                    rd_data <= sh;
                                    rd_valid <= 1'b1;
                                end else if (sda_s[1]) begin
                                    nacked <= 1'b1;
                                end
                                bitn <= 4'h0;
                                if (last || (sda_s[1] && !(rdm && bidx != 3'h0))) begin
                                    state <= HTH_STOP;
                                end else begin
                                    bidx <= bidx + 3'h1;
                                    sh <= rdm ? 8'h00 : wbuf[23:16];
                                    wbuf <= {wbuf[15:0], 8'h00};
                                end
                            end
                        end
                    end
                end
                HTH_STOP: begin
                    if (tick) begin
                        ph <= !ph;
                        if (!ph) begin
                            scl_q <= 1'b0;
                            sda_q <= 1'b0;
                        end else begin
                            scl_q <= 1'b1;
                            state <= HTH_END;
                        end
                    end
                end
                HTH_END: begin
                    if (tick) begin
                        sda_q <= 1'b1;
                        done <= 1'b1;
                        state <= HTH_IDLE;
                    end
                end
                default: begin
                    state <= HTH_IDLE;
                end
            endcase
        end
    end

    assign busy = (state != HTH_IDLE);
    assign bus.scl_o = 1'b0;
    assign bus.scl_oe = !scl_q;
    assign bus.sda_host_o = 1'b0;
    assign bus.sda_host_oe = !sda_q;
endmodule

// File: test/hti_checker.sv
`timescale 1ns/1ps
// ======================================================
// bus checker
module hti_checker #(
    parameter int STABLE_CYCLES = 200
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_dev_oe
);
    logic scl_q, sda_q, first, hit, rd;
    logic [7:0] lo_cnt, hi_cnt, sh;
    logic [3:0] bit_idx;
    int up_cnt;
    wire start_ev = scl && scl_q && sda_q && !sda;
    wire stop_ev = scl && scl_q && !sda_q && sda;
    wire rise = scl && !scl_q;
    wire fall = !scl && scl_q;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
        end
    end
    // saturating so a long idle never wraps
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            lo_cnt <= 8'h00;
            hi_cnt <= 8'h00;
            up_cnt <= 0;
        end else begin
            lo_cnt <= scl ? 8'h00 : (lo_cnt == 8'hff ? lo_cnt : lo_cnt + 8'h01);
            hi_cnt <= !scl ? 8'h00 : (hi_cnt == 8'hff ? hi_cnt : hi_cnt + 8'h01);
            up_cnt <= (up_cnt < STABLE_CYCLES) ? up_cnt + 1 : up_cnt;
        end
    end
    // bit_idx starts at f so the fall right after start lands on 0
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bit_idx <= 4'h0;
            sh <= 8'h00;
            first <= 1'b0;
            hit <= 1'b0;
            rd <= 1'b0;
        end else if (start_ev) begin
            bit_idx <= 4'hf;
            first <= 1'b1;
            hit <= 1'b0;
        end else if (stop_ev) begin
            first <= 1'b0;
            hit <= 1'b0;
        end else begin
            if (rise) sh <= {sh[6:0], sda};
            if (fall) begin
                bit_idx <= (bit_idx == 4'h8) ? 4'h0 : bit_idx + 4'h1;
                if (bit_idx == 4'h8) first <= 1'b0;
                if (first && bit_idx == 4'h7) begin
                    hit <= (sh[7:1] == hti_pkg::TARGET_ADDR);
                    rd <= sh[0];
                end
            end
        end
    end
    // ======================================================
    // properties
    scl_low_min_a: assert property ($rose(scl) |-> lo_cnt >= 8'h5e)
        else $error("scl low phase too short");
    scl_high_min_a: assert property ($fell(scl) |-> hi_cnt >= 8'h50)
        else $error("scl high phase too short");
    pwrup_idle_a: assert property (up_cnt < STABLE_CYCLES |-> scl && sda)
        else $error("bus active during power-up wait");
    start_hold_a: assert property (start_ev |=> scl [*8])
        else $error("scl not held after start");
    stop_idle_a: assert property (stop_ev |=> (scl && sda) [*8])
        else $error("bus not idle after stop");
    addr_ack_a: assert property (rise && first && bit_idx == 4'h8 |-> sda == !hit)
        else $error("address ack wrong");
    wr_quiet_a: assert property (rise && hit && !rd && bit_idx != 4'h8 |-> !sda_dev_oe)
        else $error("device drives during write data");
    ack_release_a: assert property (fall && hit && !rd && bit_idx == 4'h8 |-> ##[0:4] !sda_dev_oe)
        else $error("ack not released");
    data_hold_a: assert property ($rose(scl) |=> $stable(sda) [*8])
        else $error("sda moved while scl high");
    dev_edge_a: assert property ($changed(sda_dev_oe) |-> !scl && !$past(scl))
        else $error("device data changed outside scl low");

    cover property (rise && first && bit_idx == 4'h8 && !sda);
    cover property (rise && hit && rd && bit_idx == 4'h8 && sda);
    cover property (stop_ev);
endmodule

// File: test/test_humidity_temp_i2c_readout.sv
`timescale 1ns/1ps
// ======================================================
// bench top
module test_humidity_temp_i2c_readout;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic go = 1'b0;
    logic rd = 1'b0;
    logic [1:0] nbytes = 2'h0;
    logic [7:0] wb0 = 8'h00, wb1 = 8'h00, wb2 = 8'h00;
    logic [2:0] rd_len = 3'h1;
    logic [19:0] hum_s = 20'h00000, temp_s = 20'h00000;
    logic h_ready, h_busy, h_done, nacked, rd_valid, d_ready, bus_busy, seen_bb, seen_meas;
    logic [7:0] rd_data, status_byte;
    logic [19:0] hum_r, temp_r;
    logic [7:0] rbuf [0:7];
    logic [7:0] e [0:6];
    int nrd = 0, mismatches = 0, n_tests = 0;
    hti_if bus_if();

    always #25 mclk = ~mclk;

    // short counts keep the run small
    // measurement outlasts one address phase so a status read can see busy
    hti_dev #(.STABLE_CYCLES(200), .MEAS_CYCLES(4000)) hti_dev_i (
        .mclk(mclk), .rst(rst), .bus(bus_if), .hum_sample(hum_s), .temp_sample(temp_s),
        .ready(d_ready), .bus_busy(bus_busy), .status_byte(status_byte),
        .hum_result(hum_r), .temp_result(temp_r));
    hti_host #(.WAIT_CYCLES(200)) hti_host_i (
        .mclk(mclk), .rst(rst), .bus(bus_if), .go(go), .rd(rd), .nbytes(nbytes),
        .wb0(wb0), .wb1(wb1), .wb2(wb2), .rd_len(rd_len), .ready(h_ready), .busy(h_busy),
        .done(h_done), .nacked(nacked), .rd_data(rd_data), .rd_valid(rd_valid));
    hti_checker #(.STABLE_CYCLES(200)) hti_checker_i (
        .mclk(mclk), .rst(rst), .scl(bus_if.scl), .sda(bus_if.sda),
        .sda_dev_oe(bus_if.sda_dev_oe));

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // one whole transfer; read bytes land in rbuf
    task automatic xfer(input logic r, input logic [1:0] n, input logic [7:0] b0,
            input logic [7:0] b1, input logic [7:0] b2, input logic [2:0] len);
        int k;
        k = 0;
        while ((h_ready !== 1'b1 || h_busy !== 1'b0) && k < 1000) begin
            @(posedge mclk);
            k++;
        end
        go <= 1'b1;
        rd <= r;
        nbytes <= n;
        wb0 <= b0;
        wb1 <= b1;
        wb2 <= b2;
        rd_len <= len;
        @(posedge mclk);
        go <= 1'b0;
        nrd = 0;
        seen_bb = 1'b0;
        seen_meas = 1'b0;
        k = 0;
        while (h_done !== 1'b1 && k < 30000) begin
            @(posedge mclk);
            k++;
            if (rd_valid === 1'b1) begin
                rbuf[nrd[2:0]] = rd_data;
                nrd++;
            end
            if (bus_busy === 1'b1) seen_bb = 1'b1;
            if (status_byte[7] === 1'b1) seen_meas = 1'b1;
        end
        check("done", h_done, 1'b1);
        k = 0;
        while (bus_busy !== 1'b0 && k < 50) begin
            @(posedge mclk);
            k++;
        end
        check("bus_busy after stop", bus_busy, 1'b0);
        check("bus_busy in frame", seen_bb, 1'b1);
        check("nacked", nacked, 1'b0);
        check("bytes read", nrd, r ? {29'h0, len} : 32'h0);
    endtask

    initial begin
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        repeat (100) @(posedge mclk);
        check("dev ready early", d_ready, 1'b0);
        xfer(1'b1, 2'h0, 8'h00, 8'h00, 8'h00, 3'h1);
        check("dev ready", d_ready, 1'b1);
        check("status at reset", rbuf[0], 8'h00);
        xfer(1'b0, 2'h1, hti_pkg::CMD_STATUS, 8'h00, 8'h00, 3'h1);
        xfer(1'b1, 2'h0, 8'h00, 8'h00, 8'h00, 3'h1);
        check("status after 0x71", rbuf[0], 8'h00);
        xfer(1'b0, 2'h3, hti_pkg::CMD_INIT, hti_pkg::INIT_P0, hti_pkg::INIT_P1, 3'h1);
        check("calibrated", status_byte, 8'h08);
        check("no busy on init", seen_meas, 1'b0);
        // boundary samples on the second pass
        for (int i = 0; i < 2; i++) begin
            int k;
            logic [7:0] c;
            hum_s <= i ? 20'hfffff : 20'habcde;
            temp_s <= i ? 20'h00000 : 20'h12345;
            xfer(1'b0, 2'h3, hti_pkg::CMD_TRIG, hti_pkg::TRIG_P0, hti_pkg::TRIG_P1, 3'h1);
            check("busy on trigger", seen_meas, 1'b1);
            xfer(1'b1, 2'h0, 8'h00, 8'h00, 8'h00, 3'h1);
            check("status while busy", rbuf[0], 8'h88);
            k = 0;
            while (status_byte[7] !== 1'b0 && k < 1000) begin
                @(posedge mclk);
                k++;
            end
            check("busy cleared", status_byte[7], 1'b0);
            check("hum result", hum_r, hum_s);
            check("temp result", temp_r, temp_s);
            e[0] = 8'h08;
            e[1] = hum_s[19:12];
            e[2] = hum_s[11:4];
            e[3] = {hum_s[3:0], temp_s[19:16]};
            e[4] = temp_s[15:8];
            e[5] = temp_s[7:0];
            c = hti_pkg::CRC_INIT;
            for (int j = 0; j < 6; j++) begin
                c = c ^ e[j];
                for (int b = 0; b < 8; b++) begin
                    c = c[7] ? ((c << 1) ^ hti_pkg::CRC_POLY) : (c << 1);
                end
            end
            e[6] = c;
            xfer(1'b1, 2'h0, 8'h00, 8'h00, 8'h00, 3'h7);
            for (int j = 0; j < 7; j++) begin
                check($sformatf("read byte %0d", j), rbuf[j], e[j]);
            end
        end
        test_done();
    end

    // whole run is near 72000 cycles
    initial begin
        repeat (100000) @(posedge mclk);
        mismatches++;
        test_done();
    end
endmodule
